/* hfh_pkg.sv */
// package of constants for the hdlc fifo host interface
// assumes an 8-bit register port with byte offsets as printed
package hfh_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h56;
  localparam logic [7:0] ADDR_FIFO_INFO = 8'h57;
  localparam logic [7:0] ADDR_LATCHED = 8'h55;
  localparam logic [7:0] ADDR_RX_DATA = 8'h5C;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h5D;
  localparam logic [7:0] ADDR_TX_DATA = 8'h5E;
  localparam logic [7:0] ADDR_TX_CONTROL = 8'h5F;
  localparam logic [7:0] ADDR_MAIN_IRQ_EN = 8'h40;
  // ==========================================================
  // field positions and reset values
  localparam int BIT_TX_END = 0;
  localparam int BIT_RX_OVR = 7;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_RX_EMPTY = 5;
  localparam int BIT_OPEN = 0;
  localparam int BIT_CLOSE = 1;
  localparam int BIT_VERDICT = 2;
  localparam int BIT_EOM = 0;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] TX_DATA_RST = 8'h00;
  localparam logic [7:0] UNDEF_READ = 8'h00;
  // ==========================================================
  // fifo and framing constants
  localparam int FIFO_DEPTH = 256;
  localparam int BAND_SHIFT = 4;
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam int MIN_CLOSE_FLAGS = 2;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [1:0] VERDICT_SHORT = 2'h2;
  localparam int SHORT_LIMIT = 4;
  localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

/* hfh_fifo.sv */
// simple synchronous fifo with occupancy count
// assumes one clock; pushes when full and pops when empty are ignored
`timescale 1ns/1ps
`default_nettype none
module hfh_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write side
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  // read side
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  // occupancy
  output logic [$clog2(DEPTH):0] count,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic do_push;
  logic do_pop;

  // full pushes are dropped rather than overwriting unread data
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = (count_reg == (AW+1)'(DEPTH));
  assign empty = (count_reg == '0);
  assign count = count_reg;
  assign rdata = mem[rptr_reg];

  // storage has no reset so it maps onto ram
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr_reg] <= wdata;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* hfh_crc.sv */
// bitwise crc-16 (reflected) used for the transmit frame check sequence
// assumes bits are offered least significant first, one per clock
`timescale 1ns/1ps
`default_nettype none
module hfh_crc (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic init,
  input wire logic shift,
  input wire logic din,
  // result
  output logic [15:0] crc
);
  logic [15:0] crc_reg;
  logic fb;

  assign fb = crc_reg[0] ^ din;
  assign crc = crc_reg;

  // init wins over shift so each frame starts clean
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_reg <= hfh_pkg::CRC_INIT;
    end else if (init) begin
      crc_reg <= hfh_pkg::CRC_INIT;
    end else if (shift) begin
      crc_reg <= (crc_reg >> 1) ^ (fb ? hfh_pkg::CRC_POLY_REV : 16'h0000);
    end
  end
endmodule
`default_nettype wire

/* hfh_top.sv */
// hdlc fifo host interface: register port, receive and transmit fifos
// assumes a bit-level receiver that offers whole bytes with tags, and a
// serial transmit enable of one bit per clock when tx_bit_en is high
//
// Operation
// - overrun latch sets on overrun unless a status read pops in the same cycle, write one clears, rearms after a status read pops
// - irq asserted while overrun latch, its enable and main enable are set
// - enable register holds eight enables, reset zero, gating latched bits
// - fifo information bits never feed the interrupt
// - transmit level field reports occupancy in 16-byte bands
// - transmit empty flag high exactly while the transmit fifo is empty
// - receive empty flag high exactly while the receive fifo is empty
// - receive data register shows the head byte; reading does not pop
// - reading receive status pops, presenting the next entry
// - status bit 0 marks opening byte, bit 1 closing byte
// - verdict bits: valid, bad crc, short or ragged, abort
// - packets under four bytes get verdict short with proper tags
// - control write pushes held data plus end flag as one entry
// - transmit registers are write-only; reads return a fixed value
// - transmit fifo holds 256 bytes; writes when full are dropped
// - bytes are sent least significant bit first
// - end of message appends the fcs then at least two flags
// - packet-end latch sets on end-of-message consumed or on underrun
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module hfh_top #(
  parameter int DEPTH = hfh_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // receive byte stream from the bit-level receiver
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_opening,
  input wire logic rx_closing,
  input wire logic [1:0] rx_verdict,
  // transmit serial stream
  input wire logic tx_bit_en,
  output logic tx_bit,
  // interrupt request
  output logic hdlc_irq
);
  // ==========================================================
  // registers and fifos
  typedef enum logic [3:0] {
    TX_FLAG = 4'b0001,
    TX_DATA = 4'b0010,
    TX_FCS = 4'b0100,
    TX_CLOSE = 4'b1000
  } hfh_tx_state_type;

  localparam int CW = $clog2(DEPTH) + 1;
  logic [7:0] irq_enable_reg;
  logic main_irq_en_reg;
  logic rx_ovr_reg;
  logic rx_ovr_armed_reg;
  logic tx_end_reg;
  logic [7:0] tx_hold_reg;
  logic [7:0] rdata_reg;
  logic [11:0] rx_head;
  logic [CW-1:0] rx_count;
  logic [CW-1:0] tx_count;
  logic rx_full, rx_empty, tx_full, tx_empty;
  logic [8:0] tx_head;
  logic rx_pop, tx_push, tx_pop, rx_push;
  logic [3:0] level_band;
  logic [31:0] band_full;
  logic [7:0] fifo_info;
  logic [7:0] latched;
  hfh_tx_state_type state_reg;
  logic [7:0] shreg_reg;
  logic [2:0] bitcnt_reg;
  logic [3:0] fcs_cnt_reg;
  logic [1:0] flag_cnt_reg;
  logic eom_reg;
  logic [15:0] crc;
  logic crc_init, crc_shift;
  logic underrun;

  // tagged entry: verdict, closing, opening, data kept aligned
  assign rx_push = rx_byte_valid;
  assign rx_pop = rd && (addr == hfh_pkg::ADDR_RX_STATUS);
  hfh_fifo #(.WIDTH(12), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(clk),
    .rstn(rstn),
    .push(rx_push),
    .wdata({rx_verdict, rx_closing, rx_opening, rx_byte}),
    .pop(rx_pop),
    .rdata(rx_head),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  // control write pushes held data and end flag together
  assign tx_push = wr && (addr == hfh_pkg::ADDR_TX_CONTROL);
  hfh_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(clk),
    .rstn(rstn),
    .push(tx_push),
    .wdata({wdata[hfh_pkg::BIT_EOM], tx_hold_reg}),
    .pop(tx_pop),
    .rdata(tx_head),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  // ==========================================================
  // host-visible state
  // 16-byte bands; a full 256-byte fifo saturates into the top band
  assign band_full = 32'(tx_count) >> hfh_pkg::BAND_SHIFT;
  assign level_band = (band_full > 32'd15) ? 4'hF : band_full[3:0];
  assign fifo_info = {2'b00, rx_empty, tx_empty, level_band};
  assign latched = {rx_ovr_reg, 6'h00, tx_end_reg};

  // transmit data holding register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_hold_reg <= hfh_pkg::TX_DATA_RST;
    end else if (wr && addr == hfh_pkg::ADDR_TX_DATA) begin
      tx_hold_reg <= wdata;
    end
  end

  // enables; main enable lives at a spare offset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable_reg <= hfh_pkg::IRQ_ENABLE_RST;
      main_irq_en_reg <= 1'b0;
    end else if (wr) begin
      if (addr == hfh_pkg::ADDR_IRQ_ENABLE) begin
        irq_enable_reg <= wdata;
      end
      if (addr == hfh_pkg::ADDR_MAIN_IRQ_EN) begin
        main_irq_en_reg <= wdata[0];
      end
    end
  end

  // overrun latch: a push into a full fifo with no pop in that cycle; set wins over clear, and the
  // latch rearms only once a pop has made room again
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_ovr_reg <= 1'b0;
      rx_ovr_armed_reg <= 1'b1;
    end else begin
      if (rx_push && rx_full && !rx_pop && rx_ovr_armed_reg) begin
        rx_ovr_reg <= 1'b1;
        rx_ovr_armed_reg <= 1'b0;
      end else begin
        if (wr && addr == hfh_pkg::ADDR_LATCHED
            && wdata[hfh_pkg::BIT_RX_OVR]) begin
          rx_ovr_reg <= 1'b0;
        end
        if (rx_pop && !rx_empty) begin
          rx_ovr_armed_reg <= 1'b1;
        end
      end
    end
  end

  // packet-end latch, set wins over write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_end_reg <= 1'b0;
    end else if ((tx_pop && tx_head[8]) || underrun) begin
      tx_end_reg <= 1'b1;
    end else if (wr && addr == hfh_pkg::ADDR_LATCHED
                 && wdata[hfh_pkg::BIT_TX_END]) begin
      tx_end_reg <= 1'b0;
    end
  end

  // only latched bits feed the request; fifo info never does
  assign hdlc_irq = main_irq_en_reg
    && |(latched & irq_enable_reg);

  // read data one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      case (addr)
        hfh_pkg::ADDR_IRQ_ENABLE: rdata_reg <= irq_enable_reg;
        hfh_pkg::ADDR_FIFO_INFO: rdata_reg <= fifo_info;
        hfh_pkg::ADDR_LATCHED: rdata_reg <= latched;
        hfh_pkg::ADDR_MAIN_IRQ_EN: rdata_reg <= {7'h00, main_irq_en_reg};
        hfh_pkg::ADDR_RX_DATA: rdata_reg <= rx_head[7:0];
        hfh_pkg::ADDR_RX_STATUS: rdata_reg <= {4'h0, rx_head[11:8]};
        hfh_pkg::ADDR_TX_DATA: rdata_reg <= hfh_pkg::UNDEF_READ;
        hfh_pkg::ADDR_TX_CONTROL: rdata_reg <= hfh_pkg::UNDEF_READ;
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

  // ==========================================================
  // transmit serializer
  // flags are sent without crc; fcs is sent inverted, low bit first
  assign underrun = tx_bit_en && state_reg == TX_DATA
    && bitcnt_reg == hfh_pkg::BIT_LAST && !eom_reg && tx_empty;
  assign tx_pop = tx_bit_en && !tx_empty
    && ((state_reg == TX_FLAG && bitcnt_reg == hfh_pkg::BIT_LAST
         && flag_cnt_reg == 2'd0)
        || (state_reg == TX_DATA && bitcnt_reg == hfh_pkg::BIT_LAST
            && !eom_reg));
  assign crc_init = state_reg == TX_FLAG;
  assign crc_shift = tx_bit_en && state_reg == TX_DATA;

  hfh_crc u_crc (
    .clk(clk),
    .rstn(rstn),
    .init(crc_init),
    .shift(crc_shift),
    .din(shreg_reg[0]),
    .crc(crc)
  );

  // bit sequencing; zero insertion belongs to the bit-level engine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= TX_FLAG;
      shreg_reg <= hfh_pkg::FLAG_BYTE;
      bitcnt_reg <= 3'h0;
      fcs_cnt_reg <= 4'h0;
      flag_cnt_reg <= 2'd0;
      eom_reg <= 1'b0;
    end else if (tx_bit_en) begin
      bitcnt_reg <= bitcnt_reg + 3'h1;
      shreg_reg <= shreg_reg >> 1;
      case (state_reg)
        TX_FLAG: begin
          if (bitcnt_reg == hfh_pkg::BIT_LAST) begin
            if (flag_cnt_reg != 2'd0) begin
              flag_cnt_reg <= flag_cnt_reg - 2'd1;
            end
            if (tx_pop) begin
              state_reg <= TX_DATA;
              shreg_reg <= tx_head[7:0];
              eom_reg <= tx_head[8];
            end else begin
              shreg_reg <= hfh_pkg::FLAG_BYTE;
            end
          end
        end
        TX_DATA: begin
          if (bitcnt_reg == hfh_pkg::BIT_LAST) begin
            if (eom_reg) begin
              state_reg <= TX_FCS;
              fcs_cnt_reg <= 4'h0;
            end else if (tx_pop) begin
              shreg_reg <= tx_head[7:0];
              eom_reg <= tx_head[8];
            end else begin
              // underrun: close with flags as an aborted stream
              state_reg <= TX_FLAG;
              shreg_reg <= hfh_pkg::FLAG_BYTE;
              flag_cnt_reg <= 2'(hfh_pkg::MIN_CLOSE_FLAGS - 1);
            end
          end
        end
        TX_FCS: begin
          fcs_cnt_reg <= fcs_cnt_reg + 4'h1;
          if (fcs_cnt_reg == 4'hF) begin
            state_reg <= TX_FLAG;
            shreg_reg <= hfh_pkg::FLAG_BYTE;
            flag_cnt_reg <= 2'(hfh_pkg::MIN_CLOSE_FLAGS - 1);
            eom_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= TX_FLAG;
          shreg_reg <= hfh_pkg::FLAG_BYTE;
        end
      endcase
    end
  end

  // crc frozen during fcs so its bits are read by index
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_bit <= 1'b0;
    end else if (tx_bit_en) begin
      tx_bit <= (state_reg == TX_FCS) ? ~crc[fcs_cnt_reg] : shreg_reg[0];
    end
  end

  // ==========================================================
  // checks
  chk_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
    hdlc_irq |-> main_irq_en_reg && ((rx_ovr_reg && irq_enable_reg[7])
      || (tx_end_reg && irq_enable_reg[0])))
    else $error("irq without an enabled latched bit");
  chk_ovr_irq: assert property (@(posedge clk) disable iff (!rstn)
    (rx_ovr_reg && irq_enable_reg[7] && main_irq_en_reg) |-> hdlc_irq)
    else $error("overrun irq missing");
  chk_ovr_set: assert property (@(posedge clk) disable iff (!rstn)
    (rx_push && rx_full && !rx_pop && rx_ovr_armed_reg) |=> rx_ovr_reg)
    else $error("overrun not latched");
  chk_rx_empty: assert property (@(posedge clk) disable iff (!rstn)
    fifo_info[5] == (rx_count == '0))
    else $error("rx empty flag wrong");
  chk_tx_empty: assert property (@(posedge clk) disable iff (!rstn)
    fifo_info[4] == (tx_count == '0))
    else $error("tx empty flag wrong");
  chk_data_nopop: assert property (@(posedge clk) disable iff (!rstn)
    (rd && addr == hfh_pkg::ADDR_RX_DATA) |=> $stable(rx_count)
      || $past(rx_push))
    else $error("data read popped fifo");
  chk_status_pop: assert property (@(posedge clk) disable iff (!rstn)
    (rx_pop && !rx_empty && !rx_push) |=> rx_count == $past(rx_count) - 1)
    else $error("status read did not pop");
  chk_tx_full_drop: assert property (@(posedge clk) disable iff (!rstn)
    (tx_push && tx_full && !tx_pop) |=> tx_count == $past(tx_count))
    else $error("write stored into full fifo");
  chk_tend_set: assert property (@(posedge clk) disable iff (!rstn)
    (tx_pop && tx_head[8]) |=> tx_end_reg)
    else $error("packet end not latched");
  chk_underrun_end: assert property (@(posedge clk) disable iff (!rstn)
    underrun |=> tx_end_reg)
    else $error("underrun did not latch packet end");
  cov_frame_end: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == TX_FCS ##1 state_reg == TX_FLAG);
  cov_overrun: cover property (@(posedge clk) disable iff (!rstn)
    $rose(rx_ovr_reg));
  cov_irq: cover property (@(posedge clk) disable iff (!rstn)
    $rose(hdlc_irq));
endmodule
`default_nettype wire

/* hfh_line_model.sv */
// far side of the transmit line: paces the serializer and records bits
// assumes tx_bit changes on the edge that samples tx_bit_en high
`timescale 1ns/1ps
`default_nettype none
module hfh_line_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pacing control from the bench
  input wire logic run,
  input wire logic slow,
  // serial line
  input wire logic tx_bit,
  output logic tx_bit_en
);
  // ==========================================================
  // pacing and capture
  logic phase;
  logic en_seen;
  logic bits[$];
  // a bit is taken one edge after its enable, once the register has moved
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_bit_en <= 1'b0;
      phase <= 1'b0;
      en_seen <= 1'b0;
    end else begin
      phase <= ~phase;
      tx_bit_en <= run & (~slow | phase); // slow mode: every other cycle
      en_seen <= tx_bit_en;
      if (en_seen) begin
        bits.push_back(tx_bit);
      end
    end
  end
endmodule
`default_nettype wire

/* hdlc_fifo_host_interface_test.sv */
// self-checking bench for the hdlc fifo host interface
// assumes hfh_top with its register map; the line model paces transmit
`timescale 1ns/1ps
`default_nettype none
module hdlc_fifo_host_interface_test;
  // ==========================================================
  // signals
  localparam int DEPTH = 16; // short fifo keeps full and band cases quick
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rx_byte_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_opening = 1'b0;
  logic rx_closing = 1'b0;
  logic [1:0] rx_verdict = 2'h0;
  logic tx_bit_en;
  logic tx_bit;
  logic hdlc_irq;
  logic run = 1'b1;
  logic slow = 1'b1;
  int err_count = 0;
  int comparisons = 0;
  logic [11:0] ent[0:16];
  logic [7:0] v;
  logic [7:0] b0;
  logic [7:0] b1;
  logic hit;
  always #10 clk = ~clk;
  // ==========================================================
  // design and line model
  hfh_top #(.DEPTH(DEPTH)) dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_opening(rx_opening), .rx_closing(rx_closing),
    .rx_verdict(rx_verdict), .tx_bit_en(tx_bit_en), .tx_bit(tx_bit),
    .hdlc_irq(hdlc_irq)
  );
  hfh_line_model link (
    .clk(clk), .rstn(rstn), .run(run), .slow(slow), .tx_bit(tx_bit),
    .tx_bit_en(tx_bit_en)
  );
  // ==========================================================
  // verdict and comparison
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // ==========================================================
  // register port cycles, one strobe cycle each
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_get(input logic [7:0] a, output logic [7:0] g);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 g = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string what);
    logic [7:0] g;
    rd_get(a, g);
    chk(what, e, g);
  endtask
  // polling is bounded; running out shows up as a mismatch
  task automatic wait_reg(input logic [7:0] a, input logic [7:0] m,
                          input string what);
    logic [7:0] g;
    for (int n = 0; n < 400; n++) begin
      rd_get(a, g);
      if ((g & m) === m) break;
    end
    chk(what, m, g & m);
  endtask
  task automatic rx_push(input logic [11:0] e);
    @(posedge clk);
    {rx_verdict, rx_closing, rx_opening, rx_byte} <= e;
    rx_byte_valid <= 1'b1;
    @(posedge clk);
    rx_byte_valid <= 1'b0;
  endtask
  // ==========================================================
  // expected transmit bits, earliest bit at index 0
  function automatic logic [55:0] frame_of(input logic [7:0] x,
                                           input logic [7:0] y);
    logic [15:0] c;
    logic [15:0] d;
    c = hfh_pkg::CRC_INIT;
    d = {y, x};
    for (int i = 0; i < 16; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ hfh_pkg::CRC_POLY_REV) : (c >> 1);
    end
    return {8'h7E, 8'h7E, ~c, y, x, 8'h7E};
  endfunction
  function automatic logic tail_hit(input logic [55:0] e);
    int s;
    s = link.bits.size();
    if (s < 56) return 1'b0;
    for (int k = 0; k < 56; k++) begin
      if (link.bits[s - 56 + k] !== e[k]) return 1'b0;
    end
    return 1'b1;
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hBDAD));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h56, 8'h00, "enable reset");
    rd_chk(8'h57, 8'h30, "info reset");
    rd_chk(8'h5E, 8'h00, "tx data read");
    rd_chk(8'h5F, 8'h00, "tx control read");
    rd_chk(8'hA0, 8'h00, "unmapped read");
    v = 8'($urandom);
    wr_reg(8'h56, v);
    rd_chk(8'h56, v, "enable readback");
    // receive: short packets first, then random entries
    ent[0] = {2'h2, 1'b1, 1'b1, 8'hFF};
    ent[1] = {2'h0, 1'b0, 1'b1, 8'h5A};
    ent[2] = {2'h2, 1'b1, 1'b0, 8'hA5};
    for (int i = 3; i < 17; i++) ent[i] = 12'($urandom);
    for (int i = 0; i < 17; i++) rx_push(ent[i]);
    rd_chk(8'h55, 8'h80, "overrun latch");
    wr_reg(8'h40, 8'h01);
    rd_chk(8'h40, 8'h01, "main enable");
    wr_reg(8'h56, 8'h80);
    #1 chk("irq enabled", 8'h01, {7'h00, hdlc_irq});
    wr_reg(8'h56, 8'h00);
    #1 chk("irq masked", 8'h00, {7'h00, hdlc_irq});
    wr_reg(8'h56, 8'h80);
    wr_reg(8'h55, 8'h80);
    #1 chk("irq cleared", 8'h00, {7'h00, hdlc_irq});
    rx_push(ent[16]);
    rd_chk(8'h55, 8'h00, "overrun no rearm");
    // host reads data then status for every byte
    for (int i = 0; i < DEPTH; i++) begin
      rd_chk(8'h5C, ent[i][7:0], "rx data");
      rd_chk(8'h5C, ent[i][7:0], "rx data again");
      rd_chk(8'h5D, {4'h0, ent[i][11:8]}, "rx status");
    end
    rd_chk(8'h57, 8'h30, "rx drained");
    for (int i = 0; i < 17; i++) rx_push(ent[i]);
    rd_chk(8'h55, 8'h80, "overrun rearmed");
    wr_reg(8'h55, 8'hFF);
    // transmit one two-byte message at the slow pace
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    wr_reg(8'h5E, b0);
    wr_reg(8'h5F, 8'h00);
    wr_reg(8'h5E, b1);
    wr_reg(8'h5F, 8'h01);
    hit = 1'b0;
    for (int n = 0; n < 3000 && !hit; n++) begin
      @(posedge clk);
      hit = tail_hit(frame_of(b0, b1));
    end
    chk("tx frame bits", 8'h01, {7'h00, hit});
    rd_chk(8'h55, 8'h01, "packet end latch");
    wr_reg(8'h56, 8'h01);
    #1 chk("irq packet end", 8'h01, {7'h00, hdlc_irq});
    wr_reg(8'h55, 8'h01);
    // fill the stalled transmit fifo past its depth
    run <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      wr_reg(8'h5E, 8'($urandom));
      wr_reg(8'h5F, 8'h00);
      if (i == 14) rd_chk(8'h57, 8'h00, "band 15 bytes");
      if (i == 15) rd_chk(8'h57, 8'h01, "band 16 bytes");
      if (i == 16) rd_chk(8'h57, 8'h01, "write when full");
    end
    slow <= 1'b0;
    run <= 1'b1;
    wait_reg(8'h57, 8'h10, "tx drained");
    wait_reg(8'h55, 8'h01, "underrun latch");
    conclude();
  end
endmodule
`default_nettype wire
